// ### rtl/tcc_core.sv
// eight-bit timer core: counter unit, two compare units, compare output stage
// assumes a register master on core_clk; port data and direction come from same clock
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
module tcc_core
(
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	input  wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [tcc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [tcc_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                       external_count_pin,
	input  wire logic                       int_ack_overflow,
	input  wire logic                       int_ack_match_a,
	input  wire logic                       int_ack_match_b,
	input  wire logic                       port_data_a,
	input  wire logic                       port_data_b,
	input  wire logic                       port_dir_a,
	input  wire logic                       port_dir_b,
	output logic                            irq_overflow,
	output logic                            irq_match_a,
	output logic                            irq_match_b,
	output logic                            compare_output_a_o,
	output logic                            compare_output_a_oe,
	output logic                            compare_output_b_o,
	output logic                            compare_output_b_oe
);
	import tcc_pkg::*;

	tcc_cmp_if cmp_bus ();

	logic [7:0] control_reg_a, control_reg_b, count_value, top_value;
	logic [7:0] next_ctrl_a, next_ctrl_b, next_count, next_rdata;
	logic [7:0] cmp_active [2];
	logic [7:0] cmp_read   [2];
	logic [2:0] flags, mask, next_flags, next_mask, clr, waveform_mode;
	logic [1:0] compare_output, next_oc, match, cmp_wr, match_evt, force_evt;
	logic       dir_down, block, next_dir, next_block, timer_tick;
	logic       at_top, at_bottom, ovf_evt, load, wrap, cnt_wr;

	// decoders used by several processes
	function automatic logic is_pwm(input logic [2:0] m);
		return m[0];
	endfunction

	function automatic logic is_fast(input logic [2:0] m);
		return m[1] & m[0];
	endfunction

	// next compare output state of one channel
	function automatic logic next_output(input logic oc, input logic [1:0] act,
		input logic [2:0] m, input logic evt, input logic frc, input logic wrp,
		input logic down, input logic may_toggle);
		logic r;
		r = oc;
		if (is_fast(m))
		begin
			if (wrp && act[1])
				r = ~act[0];
			else if (evt && act[1])
				r = act[0];
			else if (evt && act == ACT_TOGGLE && may_toggle)
				r = ~oc;
		end
		else if (is_pwm(m))
		begin
			if (evt && act[1])
				r = down ^ act[0];
			else if (evt && act == ACT_TOGGLE && may_toggle)
				r = ~oc;
		end
		else if (evt || frc)
		begin
			case (act)
				ACT_TOGGLE: r = ~oc;
				ACT_CLEAR:  r = 1'b0;
				ACT_SET:    r = 1'b1;
				default:    r = oc;
			endcase
		end
		return r;
	endfunction

	tcc_tick_gen u_tick (
		.core_clk            (core_clk),
		.rst_n               (rst_n),
		.clk_en              (clk_en),
		.clock_source_select (control_reg_b[CB_CS_LO+:3]),
		.external_count_pin  (external_count_pin),
		.timer_tick          (timer_tick)
	);

	// waveform mode assembled from both control registers
	assign waveform_mode = {control_reg_b[CB_WAVE_HI], control_reg_a[CA_WAVE_LO+:2]};
	assign top_value     = waveform_mode[2] ? cmp_active[0] : MAX_VAL;
	assign at_top        = (count_value == top_value);
	assign at_bottom     = (count_value == BOTTOM_VAL);
	assign cnt_wr        = reg_wr && (reg_addr == REG_COUNT);
	assign cmp_wr[0]     = reg_wr && (reg_addr == REG_CMP_A);
	assign cmp_wr[1]     = reg_wr && (reg_addr == REG_CMP_B);

	assign cmp_bus.tick        = timer_tick;
	assign cmp_bus.count_value = count_value;
	assign cmp_bus.buffered    = is_pwm(waveform_mode);
	assign cmp_bus.load        = load;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cmp
			tcc_compare_unit u_cmp (
				.core_clk      (core_clk),
				.rst_n         (rst_n),
				.clk_en        (clk_en),
				.cmp_bus       (cmp_bus.unit),
				.wr_en         (cmp_wr[gi]),
				.wr_data       (reg_wdata),
				.compare_value (cmp_active[gi]),
				.read_value    (cmp_read[gi]),
				.match         (match[gi])
			);
			// a match counts on a tick unless a counter write blocks it
			assign match_evt[gi] = timer_tick && match[gi] && !block;
			// force strobes only work outside PWM modes
			assign force_evt[gi] = reg_wr && (reg_addr == REG_CTRL_B)
				&& reg_wdata[CB_FORCE_A - gi] && !is_pwm(waveform_mode);
		end
	endgenerate

	// counter sequence per mode; a software write overrides it
	always_comb
	begin
		next_count = count_value;
		next_dir   = dir_down;
		ovf_evt    = 1'b0;
		load       = 1'b0;
		wrap       = 1'b0;
		if (timer_tick)
		begin
			case (waveform_mode)
				WM_FAST_MAX, WM_FAST_CMPA:
				begin
					if (at_top)
					begin
						next_count = BOTTOM_VAL;
						ovf_evt    = 1'b1;
						load       = 1'b1;
						wrap       = 1'b1;
					end
					else
						next_count = count_value + 8'h01;
				end
				WM_PHASE_MAX, WM_PHASE_CMPA:
				begin
					if (dir_down)
					begin
						if (at_bottom)
						begin
							next_dir   = 1'b0;
							ovf_evt    = 1'b1;
							next_count = at_top ? BOTTOM_VAL : count_value + 8'h01;
						end
						else
							next_count = count_value - 8'h01;
					end
					else if (at_top)
					begin
						next_dir   = 1'b1;
						load       = 1'b1;
						next_count = at_bottom ? BOTTOM_VAL : count_value - 8'h01;
					end
					else
						next_count = count_value + 8'h01;
				end
				WM_CLEAR:
				begin
					ovf_evt    = (count_value == MAX_VAL);
					next_count = match[0] ? BOTTOM_VAL : count_value + 8'h01;
				end
				default:
				begin
					ovf_evt    = (count_value == MAX_VAL);
					next_count = count_value + 8'h01;
				end
			endcase
		end
		// a write blocks matches on the next tick, which clears the block
		next_block = block && !timer_tick;
		if (cnt_wr)
		begin
			next_count = reg_wdata;
			next_block = 1'b1;
		end
	end

	// flags: hardware set wins over a clear in the same cycle
	always_comb
	begin
		clr[FL_OVF]     = int_ack_overflow;
		clr[FL_MATCH_A] = int_ack_match_a;
		clr[FL_MATCH_B] = int_ack_match_b;
		if (reg_wr && (reg_addr == REG_FLAGS))
			clr = clr | reg_wdata[2:0];
		next_flags             = flags & ~clr;
		next_flags[FL_OVF]     = next_flags[FL_OVF] | ovf_evt;
		next_flags[FL_MATCH_A] = next_flags[FL_MATCH_A] | match_evt[0];
		next_flags[FL_MATCH_B] = next_flags[FL_MATCH_B] | match_evt[1];
		next_mask              = mask;
		if (reg_wr && (reg_addr == REG_MASK))
			next_mask = reg_wdata[2:0];
	end

	// control registers; force strobes read back as zero
	always_comb
	begin
		next_ctrl_a = control_reg_a;
		next_ctrl_b = control_reg_b;
		if (reg_wr && (reg_addr == REG_CTRL_A))
			next_ctrl_a = reg_wdata;
		if (reg_wr && (reg_addr == REG_CTRL_B))
			next_ctrl_b = reg_wdata & CTRL_B_KEEP;
	end

	// compare output state; action bits act at once, no buffering
	always_comb
	begin
		next_oc[0] = next_output(compare_output[0], control_reg_a[CA_ACT_A_LO+:2],
			waveform_mode, match_evt[0], force_evt[0], wrap, dir_down,
			waveform_mode[2]);
		next_oc[1] = next_output(compare_output[1], control_reg_a[CA_ACT_B_LO+:2],
			waveform_mode, match_evt[1], force_evt[1], wrap, dir_down, 1'b0);
	end

	// read mux; data stand only in the cycle after the strobe
	always_comb
	begin
		next_rdata = RST_BYTE;
		if (reg_rd)
		begin
			case (reg_addr)
				REG_CTRL_A: next_rdata = control_reg_a;
				REG_CTRL_B: next_rdata = control_reg_b;
				REG_COUNT:  next_rdata = count_value;
				REG_CMP_A:  next_rdata = cmp_read[0];
				REG_CMP_B:  next_rdata = cmp_read[1];
				REG_FLAGS:  next_rdata = {5'h00, flags};
				REG_MASK:   next_rdata = {5'h00, mask};
				default:    next_rdata = RST_BYTE;
			endcase
		end
	end

	// all state registers; interrupt outputs registered from next flags and mask, pin outputs from current state
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			control_reg_a       <= RST_BYTE;
			control_reg_b       <= RST_BYTE;
			count_value         <= RST_BYTE;
			flags               <= RST_FLAGS;
			mask                <= RST_FLAGS;
			dir_down            <= 1'b0;
			block               <= 1'b0;
			compare_output      <= 2'h0;
			reg_rdata           <= RST_BYTE;
			irq_overflow        <= 1'b0;
			irq_match_a         <= 1'b0;
			irq_match_b         <= 1'b0;
			compare_output_a_o  <= 1'b0;
			compare_output_a_oe <= 1'b0;
			compare_output_b_o  <= 1'b0;
			compare_output_b_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			control_reg_a       <= next_ctrl_a;
			control_reg_b       <= next_ctrl_b;
			count_value         <= next_count;
			flags               <= next_flags;
			mask                <= next_mask;
			dir_down            <= next_dir;
			block               <= next_block;
			compare_output      <= next_oc;
			reg_rdata           <= next_rdata;
			irq_overflow        <= next_flags[FL_OVF] & next_mask[FL_OVF];
			irq_match_a         <= next_flags[FL_MATCH_A] & next_mask[FL_MATCH_A];
			irq_match_b         <= next_flags[FL_MATCH_B] & next_mask[FL_MATCH_B];
			// override port data while an action is selected
			compare_output_a_o  <= (|control_reg_a[CA_ACT_A_LO+:2]) ?
				compare_output[0] : port_data_a;
			compare_output_b_o  <= (|control_reg_a[CA_ACT_B_LO+:2]) ?
				compare_output[1] : port_data_b;
			compare_output_a_oe <= port_dir_a;
			compare_output_b_oe <= port_dir_b;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_count_write_wins: assert property (clk_en && cnt_wr |=> count_value == $past(reg_wdata))
		else $error("counter write did not win");
	chk_stopped_holds: assert property (clk_en && !cnt_wr && control_reg_b[2:0] == CS_STOP
		&& $past(control_reg_b[2:0]) == CS_STOP |=> count_value == $past(count_value))
		else $error("stopped counter moved");
	chk_normal_counts_up: assert property (clk_en && timer_tick && !cnt_wr
		&& waveform_mode == WM_NORMAL |=> count_value == 8'($past(count_value) + 8'h01))
		else $error("normal mode did not increment");
	chk_match_sets_flag: assert property (clk_en && timer_tick && match[0] && !block
		|=> flags[FL_MATCH_A])
		else $error("match did not set flag");
	chk_write_blocks_match: assert property (clk_en && cnt_wr ##1 (clk_en && timer_tick
		&& !flags[FL_MATCH_B] && !cnt_wr) |=> !flags[FL_MATCH_B])
		else $error("blocked match set flag");
	chk_irq_level: assert property (irq_match_a == (flags[FL_MATCH_A] & mask[FL_MATCH_A]))
		else $error("interrupt not tied to flag");
	chk_flag_clear_write: assert property (clk_en && reg_wr && reg_addr == REG_FLAGS
		&& reg_wdata[FL_OVF] && !ovf_evt |=> !flags[FL_OVF])
		else $error("write one did not clear flag");
	chk_pin_override: assert property (clk_en && control_reg_a[CA_ACT_A_LO+:2] != 2'h0
		|=> compare_output_a_o == $past(compare_output[0]))
		else $error("pin not overridden");
	chk_zero_action_holds: assert property (clk_en && control_reg_a[CA_ACT_B_LO+:2] == 2'h0
		|=> compare_output[1] == $past(compare_output[1]))
		else $error("output changed with no action");
	chk_force_no_flag: assert property (clk_en && force_evt[0] && !match_evt[0]
		&& !flags[FL_MATCH_A] |=> !flags[FL_MATCH_A])
		else $error("force set flag");

	cov_overflow: cover property (clk_en && ovf_evt);
	cov_fast_wrap: cover property (clk_en && wrap && is_fast(waveform_mode));
	cov_force: cover property (clk_en && force_evt[1]);
	cov_phase_turn: cover property (clk_en && load && is_pwm(waveform_mode) && !wrap);
endmodule

// ### rtl/tcc_pkg.sv
// constants and types shared by the timer/counter compare core
// assumes a single 50 MHz core clock and an 8-bit register port
package tcc_pkg;
	localparam int CLK_HZ      = 50000000;
	localparam int ADDR_W      = 3;
	localparam int DATA_W      = 8;
	localparam int PRESCALE_W  = 10;

	// register indices on the plain register port
	localparam logic [2:0] REG_CTRL_A  = 3'h0;
	localparam logic [2:0] REG_CTRL_B  = 3'h1;
	localparam logic [2:0] REG_COUNT   = 3'h2;
	localparam logic [2:0] REG_CMP_A   = 3'h3;
	localparam logic [2:0] REG_CMP_B   = 3'h4;
	localparam logic [2:0] REG_FLAGS   = 3'h5;
	localparam logic [2:0] REG_MASK    = 3'h6;

	// field positions
	localparam int CA_WAVE_LO  = 0;
	localparam int CA_ACT_B_LO = 4;
	localparam int CA_ACT_A_LO = 6;
	localparam int CB_CS_LO    = 0;
	localparam int CB_WAVE_HI  = 3;
	localparam int CB_FORCE_B  = 6;
	localparam int CB_FORCE_A  = 7;
	localparam int FL_OVF      = 0;
	localparam int FL_MATCH_A  = 1;
	localparam int FL_MATCH_B  = 2;

	// values after reset and counter limits
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [2:0] RST_FLAGS   = 3'h0;
	localparam logic [7:0] BOTTOM_VAL  = 8'h00;
	localparam logic [7:0] MAX_VAL     = 8'hFF;
	localparam logic [7:0] CTRL_B_KEEP = 8'h0F;
	localparam logic [PRESCALE_W-1:0] PRE_RST = 10'h000;

	typedef enum logic [2:0] {
		WM_NORMAL     = 3'b000,
		WM_PHASE_MAX  = 3'b001,
		WM_CLEAR      = 3'b010,
		WM_FAST_MAX   = 3'b011,
		WM_PHASE_CMPA = 3'b101,
		WM_FAST_CMPA  = 3'b111
	} tcc_mode_type;

	typedef enum logic [2:0] {
		CS_STOP      = 3'h0,
		CS_DIV1      = 3'h1,
		CS_DIV8      = 3'h2,
		CS_DIV64     = 3'h3,
		CS_DIV256    = 3'h4,
		CS_DIV1024   = 3'h5,
		CS_EXT_FALL  = 3'h6,
		CS_EXT_RISE  = 3'h7
	} tcc_cs_type;

	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_CLEAR  = 2'h2,
		ACT_SET    = 2'h3
	} tcc_action_type;
endpackage

// ### rtl/tcc_cmp_if.sv
// shared signals from the counter unit to the compare units
// assumes one driver (the core) and any number of compare units
`timescale 1ns/1ns
interface tcc_cmp_if;
	logic       tick;
	logic [7:0] count_value;
	logic       buffered;
	logic       load;
	modport core (output tick, output count_value, output buffered, output load);
	modport unit (input tick, input count_value, input buffered, input load);
endinterface

// ### rtl/tcc_tick_gen.sv
// timer tick source: free running prescaler and external count pin edge detect
// assumes external_count_pin is asynchronous to core_clk
`timescale 1ns/1ns
module tcc_tick_gen
	import tcc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [2:0] clock_source_select,
	input  wire logic       external_count_pin,
	output logic            timer_tick
);
	logic [PRESCALE_W-1:0] pre;
	logic [PRESCALE_W-1:0] next_pre;
	logic [2:0]            pin_sync;
	logic [2:0]            next_pin_sync;
	logic                  next_tick;

	// prescaler taps fire when the low bits are all ones; pin edge on stages 2 and 3
	always_comb
	begin
		next_pre      = pre + 10'h001;
		next_pin_sync = {pin_sync[1:0], external_count_pin};
		case (clock_source_select)
			CS_STOP:     next_tick = 1'b0;
			CS_DIV1:     next_tick = 1'b1;
			CS_DIV8:     next_tick = &pre[2:0];
			CS_DIV64:    next_tick = &pre[5:0];
			CS_DIV256:   next_tick = &pre[7:0];
			CS_DIV1024:  next_tick = &pre[9:0];
			CS_EXT_FALL: next_tick = pin_sync[2] & ~pin_sync[1];
			CS_EXT_RISE: next_tick = ~pin_sync[2] & pin_sync[1];
			default:     next_tick = 1'b0;
		endcase
	end

	// register stage; first synchroniser flop feeds only the second
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pre        <= PRE_RST;
			pin_sync   <= 3'h0;
			timer_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			pre        <= next_pre;
			pin_sync   <= next_pin_sync;
			timer_tick <= next_tick;
		end
	end
endmodule

// ### rtl/tcc_compare_unit.sv
// one output compare unit: buffer register, active compare register, comparator
// assumes the core drives the shared compare bus and a one-cycle write strobe
`timescale 1ns/1ns
module tcc_compare_unit
	import tcc_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rst_n,
	input  wire logic  clk_en,
	tcc_cmp_if.unit    cmp_bus,
	input  wire logic  wr_en,
	input  wire logic [7:0] wr_data,
	output logic [7:0] compare_value,
	output logic [7:0] read_value,
	output logic       match
);
	logic [7:0] buffer_value;
	logic [7:0] next_buffer;
	logic [7:0] next_compare;

	// buffered writes land in the buffer; otherwise both take the value
	// a load beside a write still takes the old buffer, so no period mixes values
	always_comb
	begin
		next_buffer  = buffer_value;
		next_compare = compare_value;
		if (wr_en)
			next_buffer = wr_data;
		if (wr_en && !cmp_bus.buffered)
			next_compare = wr_data;
		else if (cmp_bus.buffered && cmp_bus.load && cmp_bus.tick)
			next_compare = buffer_value;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			buffer_value  <= RST_BYTE;
			compare_value <= RST_BYTE;
		end
		else if (clk_en)
		begin
			buffer_value  <= next_buffer;
			compare_value <= next_compare;
		end
	end

	// comparator runs all the time, gating by tick is the core's job
	assign match      = (cmp_bus.count_value == compare_value);
	assign read_value = cmp_bus.buffered ? buffer_value : compare_value;
endmodule

// ### verif/tcc_pin_model.sv
// external count source driving the timer's count pin
// assumes one burst is requested at a time and the pin idles low
`timescale 1ns/1ns
module tcc_pin_model
(
	input  wire logic       core_clk,
	input  wire logic       go,
	input  wire logic [3:0] pulses,
	output logic            external_count_pin
);
	logic [3:0] left;
	logic [2:0] phase;

	// start idle so the edge detector sees no false edge
	initial
	begin
		external_count_pin = 1'b0;
		left = 4'h0;
		phase = 3'h0;
	end

	// 4 cycles high, 4 low: well under half the core clock rate
	always @(posedge core_clk)
	begin
		if (go)
		begin
			left <= pulses;
			phase <= 3'h0;
		end
		else if (left != 4'h0)
		begin
			phase <= phase + 3'h1;
			external_count_pin <= (phase < 3'h4);
			if (phase == 3'h7)
				left <= left - 4'h1;
		end
		else
			external_count_pin <= 1'b0;
	end
endmodule

// ### verif/tcc_core_bench.sv
// self-checking bench for the timer compare core
// assumes the register port and the pin model are the only traffic
`timescale 1ns/1ns
module tcc_core_bench;
	import tcc_pkg::*;
	logic       core_clk, rst_n, reg_wr, reg_rd, go, ack_a, pd_a, dir_a, ce;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd;
	logic [3:0] pulses;
	logic       irq_o, irq_a, irq_b, oa, oae, ob, obe, pin;
	logic [7:0] acts [3] = '{8'hC0, 8'h80, 8'h40};
	logic [7:0] exps [3] = '{8'h01, 8'h00, 8'h01};
	int         n_errors, tests_run, i;

	tcc_core dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_count_pin(pin),
		.int_ack_overflow(1'b0), .int_ack_match_a(ack_a), .int_ack_match_b(1'b0),
		.port_data_a(pd_a), .port_data_b(1'b0), .port_dir_a(dir_a), .port_dir_b(1'b0),
		.irq_overflow(irq_o), .irq_match_a(irq_a), .irq_match_b(irq_b),
		.compare_output_a_o(oa), .compare_output_a_oe(oae),
		.compare_output_b_o(ob), .compare_output_b_oe(obe));

	tcc_pin_model src (.core_clk(core_clk), .go(go), .pulses(pulses),
		.external_count_pin(pin));

	always #10 core_clk = ~core_clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rdr(input logic [2:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
		rdr(a);
		check(what, rd, exp);
	endtask

	task automatic burst(input logic [3:0] n);
		@(posedge core_clk);
		go <= 1'b1;
		pulses <= n;
		@(posedge core_clk);
		go <= 1'b0;
		cyc(80);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		conclude();
	end

	initial
	begin
		{core_clk, rst_n, reg_wr, reg_rd, go, ack_a, pd_a, dir_a} = 8'h00;
		ce = 1'b1;
		{reg_addr, reg_wdata, pulses} = 15'h0000;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		cyc(2);
		check("irqs", {5'h00, irq_o, irq_a, irq_b}, 8'h00);
		check("pins", {4'h0, oa, oae, ob, obe}, 8'h00);
		rdc(REG_COUNT, 8'h00, "count");
		wr(REG_COUNT, 8'h05);
		cyc(20);
		rdc(REG_COUNT, 8'h05, "stopped");
		// enable low freezes tick and counter: only two ticks reach the count
		wr(REG_CTRL_B, 8'h01);
		ce <= 1'b0;
		cyc(10);
		ce <= 1'b1;
		wr(REG_CTRL_B, 8'h00);
		rdc(REG_COUNT, 8'h07, "frozen");
		// counter loaded equal to compare A: first tick must not match
		wr(REG_CMP_A, 8'h20);
		wr(REG_COUNT, 8'h20);
		wr(REG_MASK, 8'h03);
		wr(REG_FLAGS, 8'h07);
		wr(REG_CTRL_B, 8'h01);
		cyc(8);
		rdc(REG_FLAGS, 8'h00, "blocked");
		for (i = 0; i < 400 && irq_a !== 1'b1; i++)
			@(posedge core_clk);
		rdc(REG_FLAGS, 8'h07, "wrapped");
		@(posedge core_clk);
		ack_a <= 1'b1;
		@(posedge core_clk);
		ack_a <= 1'b0;
		cyc(1);
		check("ack", {7'h00, irq_a}, 8'h00);
		wr(REG_FLAGS, 8'h01);
		rdc(REG_FLAGS, 8'h04, "w1c");
		check("ovf irq", {7'h00, irq_o}, 8'h00);
		// clear on match: count never passes compare A
		wr(REG_CTRL_A, 8'h02);
		wr(REG_CMP_A, 8'h03);
		wr(REG_COUNT, 8'h00);
		for (i = 0; i < 10; i++)
		begin
			rdr(REG_COUNT);
			check("ctc", {7'h00, rd <= 8'h03}, 8'h01);
		end
		wr(REG_CTRL_A, 8'h00);
		wr(REG_CTRL_B, 8'h07);
		wr(REG_COUNT, 8'h00);
		burst(4'h4);
		rdc(REG_COUNT, 8'h04, "rising");
		wr(REG_CTRL_B, 8'h06);
		wr(REG_COUNT, 8'h00);
		burst(4'h3);
		rdc(REG_COUNT, 8'h03, "falling");
		// divide by eight: eighty enabled edges give exactly ten ticks
		wr(REG_CTRL_B, 8'h02);
		cyc(78);
		wr(REG_CTRL_B, 8'h00);
		rdc(REG_COUNT, 8'h0D, "div8");
		// phase correct: six ticks climb to the top, turn and come back down
		wr(REG_CTRL_A, 8'h01);
		wr(REG_COUNT, 8'hFD);
		wr(REG_CTRL_B, 8'h01);
		cyc(4);
		wr(REG_CTRL_B, 8'h00);
		rdc(REG_COUNT, 8'hFB, "phase");
		// fast mode: new compare A waits in the buffer until bottom
		wr(REG_CTRL_A, 8'h03);
		wr(REG_CTRL_B, 8'h00);
		wr(REG_CMP_A, 8'h0A);
		wr(REG_COUNT, 8'h08);
		wr(REG_FLAGS, 8'h07);
		wr(REG_CTRL_B, 8'h01);
		cyc(8);
		rdc(REG_FLAGS, 8'h00, "buffered");
		rdc(REG_CMP_A, 8'h0A, "buffer read");
		wr(REG_CTRL_B, 8'h00);
		wr(REG_CTRL_A, 8'h00);
		wr(REG_FLAGS, 8'h07);
		pd_a <= 1'b1;
		cyc(3);
		check("port", {6'h00, oa, oae}, 8'h02);
		pd_a <= 1'b0;
		// forced actions with port data low: set, clear, toggle
		for (i = 0; i < 3; i++)
		begin
			wr(REG_CTRL_A, acts[i]);
			wr(REG_CTRL_B, 8'h80);
			cyc(3);
			check("force", {7'h00, oa}, exps[i]);
		end
		dir_a <= 1'b1;
		wr(REG_CTRL_A, 8'h42);
		cyc(3);
		check("kept", {6'h00, oa, oae}, 8'h03);
		rdc(REG_FLAGS, 8'h00, "no flag");
		wr(REG_CTRL_A, 8'h30);
		wr(REG_CTRL_B, 8'h40);
		cyc(3);
		check("force b", {6'h00, ob, obe}, 8'h02);
		conclude();
	end
endmodule
